// file: bgpc_regs.svh
// constants for the grant priority chain device logic
`ifndef BGPC_REGS_SVH
`define BGPC_REGS_SVH
`define BGPC_SIGNAL_LINES 56
`define BGPC_LEVELS 5
`define BGPC_WORD_BITS 16
`define BGPC_BYTE_BITS 8
`define BGPC_ADDR_BITS 18
`define BGPC_SYNC_STAGES 2
`endif

// file: bgpc_pkg.sv
// types shared by the grant priority chain device logic
package bgpc_pkg;
    typedef enum logic [1:0] {
        BGPC_IDLE,
        BGPC_REQ,
        BGPC_GRANTED,
        BGPC_MASTER
    } bgpc_state_type;

    typedef struct packed {
        logic [4:0] grantIn;
        logic busBusy;
        logic ackSeen;
    } bgpc_bus_in_type;

    typedef struct packed {
        logic [4:0] grantOut;
        logic [4:0] request;
        logic ack;
        logic master;
    } bgpc_bus_out_type;
endpackage

// file: bgpc_sync.sv
// two-stage synchroniser for a vector of bus inputs
`timescale 1ns/1ps
`default_nettype none
module bgpc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: bgpc_slave_match.sv
// slave address recognition for data group access
`timescale 1ns/1ps
`default_nettype none
module bgpc_slave_match #(
    parameter int ADDR_BITS = 18,
    parameter logic [17:0] BASE = 18'h3F000,
    parameter logic [17:0] MASK = 18'h3FFF0
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic addrValid,
    output logic selected
);
    // respond only to addresses that match BASE under MASK
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            selected <= 1'b0;
        end else begin
            selected <= addrValid && ((addr & MASK) == (BASE & MASK));
        end
    end
endmodule
`default_nettype wire

// file: bgpc_device.sv
// device end of the bus grant priority chain
// Functional notes
// - bus has 56 lines: initialization, data and arbitration groups.
// - at most one device is master at a time.
// - at most one slave answers the current master.
// - exactly one arbitrator per bus.
// - data moves as a 16-bit word or 8-bit byte.
// - master drives slave address; slave answers only its own address.
// - device may request whenever ready; many may request together.
// - request lines are wired-OR, read only by the arbitrator.
// - each of five grant lines: take from upstream, pass or block.
// - grant travels on until blocked or it reaches the far end.
// - priority: level first, then chain position within level.
// - master-capable device sits on one of five request levels.
// - requesting device takes its grant, acknowledges and blocks it.
`include "bgpc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bgpc_device #(
    parameter int LEVELS = `BGPC_LEVELS,
    parameter int ADDR_BITS = `BGPC_ADDR_BITS,
    parameter logic [2:0] LEVEL = 3'h4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic xferReady,
    input wire logic xferDone,
    input wire logic byteMode,
    input wire logic [ADDR_BITS-1:0] slaveAddr,
    input wire logic addrValid,
    input wire bgpc_pkg::bgpc_bus_in_type busIn,
    output bgpc_pkg::bgpc_bus_out_type busOut,
    output logic [`BGPC_WORD_BITS-1:0] dataMask,
    output logic slaveSelected
);
    bgpc_pkg::bgpc_state_type state;
    bgpc_pkg::bgpc_state_type next_state;
    bgpc_pkg::bgpc_bus_in_type syncIn;
    logic myGrant;
    logic blocking;

    bgpc_sync #(.WIDTH($bits(bgpc_pkg::bgpc_bus_in_type))) inSync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async(busIn),
        .synced(syncIn)
    );

    bgpc_slave_match #(.ADDR_BITS(ADDR_BITS)) slaveMatch (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .addr(slaveAddr),
        .addrValid(addrValid && !busOut.master),
        .selected(slaveSelected)
    );

    // grants come only from the single upstream arbitrator
    assign myGrant = syncIn.grantIn[LEVEL];

    always_comb begin
        next_state = state;
        case (state)
            bgpc_pkg::BGPC_IDLE: begin
                if (xferReady) begin
                    next_state = bgpc_pkg::BGPC_REQ;
                end
            end
            bgpc_pkg::BGPC_REQ: begin
                if (myGrant) begin
                    next_state = bgpc_pkg::BGPC_GRANTED;
                end
            end
            bgpc_pkg::BGPC_GRANTED: begin
                // wait for the current master to release the data group
                if (!syncIn.busBusy) begin
                    next_state = bgpc_pkg::BGPC_MASTER;
                end
            end
            bgpc_pkg::BGPC_MASTER: begin
                if (xferDone) begin
                    next_state = bgpc_pkg::BGPC_IDLE;
                end
            end
            default: next_state = bgpc_pkg::BGPC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= bgpc_pkg::BGPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // block from grant capture until master ownership begins
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            blocking <= 1'b0;
        end else begin
            blocking <= (next_state == bgpc_pkg::BGPC_GRANTED);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busOut <= '0;
            dataMask <= '0;
        end else begin
            for (int i = 0; i < LEVELS; i++) begin
                // pass downstream unless we take this level's grant
                busOut.grantOut[i] <= syncIn.grantIn[i] &&
                    !(i == int'(LEVEL) && (state == bgpc_pkg::BGPC_REQ || blocking));
            end
            busOut.request <= '0;
            busOut.request[LEVEL] <= (next_state == bgpc_pkg::BGPC_REQ);
            busOut.ack <= (next_state == bgpc_pkg::BGPC_GRANTED);
            busOut.master <= (next_state == bgpc_pkg::BGPC_MASTER);
            dataMask <= byteMode ? 16'h00FF : 16'hFFFF;
        end
    end
endmodule
`default_nettype wire

// file: bgpc_device_asserts.sv
// port checker for the grant chain device
`timescale 1ns/1ps
`default_nettype none
module bgpc_device_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic xferReady,
    input wire logic xferDone,
    input wire logic byteMode,
    input wire logic [17:0] slaveAddr,
    input wire logic addrValid,
    input wire bgpc_pkg::bgpc_bus_in_type busIn,
    input wire bgpc_pkg::bgpc_bus_out_type busOut,
    input wire logic [15:0] dataMask,
    input wire logic slaveSelected
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_fwd; busOut.grantOut[3:0] == $past(busIn.grantIn[3:0], 3); endproperty
    a_fwd: assert property (p_fwd) else $error("fwd");
    property p_req; xferReady && busOut[6:0] == 7'h0 |=> busOut.request[4]; endproperty
    a_req: assert property (p_req) else $error("req");
    property p_blk; busOut.request[4] |=> !busOut.grantOut[4]; endproperty
    a_blk: assert property (p_blk) else $error("blk");
    property p_ack; $rose(busOut.ack) |-> $past(busIn.grantIn[4], 3) && !busOut.request[4]; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_mst; $rose(busOut.master) |-> $past(busOut.ack) && !$past(busIn.busBusy, 3); endproperty
    a_mst: assert property (p_mst) else $error("mst");
    property p_end; busOut.master && xferDone |=> !busOut.master; endproperty
    a_end: assert property (p_end) else $error("end");
    property p_msk; busOut.master |-> dataMask == ($past(byteMode) ? 16'h00FF : 16'hFFFF); endproperty
    a_msk: assert property (p_msk) else $error("msk");
    property p_sel;
        slaveSelected == $past(addrValid && !busOut.master && (slaveAddr & 18'h3FFF0) == 18'h3F000);
    endproperty
    a_sel: assert property (p_sel) else $error("sel");
    c_ack: cover property ($rose(busOut.ack));
    c_mst: cover property ($rose(busOut.master));
    c_sel: cover property (slaveSelected);
endmodule
bind bgpc_device bgpc_device_asserts bgpc_device_asserts_i (.ref_clk, .rstn, .xferReady,
    .xferDone, .byteMode, .slaveAddr, .addrValid, .busIn, .busOut, .dataMask, .slaveSelected);
`default_nettype wire

// file: bgpc_arb_model.sv
// arbitrator model for the device's own grant level
`timescale 1ns/1ps
`default_nettype none
module bgpc_arb_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [4:0] request,
    input wire logic ack,
    output logic grant,
    output logic busy
);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            grant <= 1'h0;
            busy <= 1'h0;
        end else begin
            grant <= request[4] & ~ack;
            busy <= grant;
        end
    end
endmodule
`default_nettype wire

// file: bus_grant_priority_chain_tb.sv
// testbench for the grant chain device
`timescale 1ns/1ps
`default_nettype none
module bus_grant_priority_chain_tb;
    logic ref_clk = 1'h0, rstn = 1'h0, xferReady = 1'h0, xferDone = 1'h0;
    logic byteMode = 1'h0, addrValid = 1'h0, mGrant, mBusy, slaveSelected;
    logic [17:0] slaveAddr = 18'h0;
    logic [4:0] tbGrant = 5'h0;
    logic [15:0] dataMask;
    bgpc_pkg::bgpc_bus_in_type busIn;
    bgpc_pkg::bgpc_bus_out_type busOut;
    int fail_count = 0, tests_run = 0, cycles = 0;
    assign busIn = '{grantIn: tbGrant | {mGrant, 4'h0}, busBusy: mBusy, ackSeen: busOut.ack};
    always #5 ref_clk = ~ref_clk;
    bgpc_device bgpc_device_i (.ref_clk(ref_clk), .rstn(rstn), .xferReady(xferReady),
        .xferDone(xferDone), .byteMode(byteMode), .slaveAddr(slaveAddr), .addrValid(addrValid),
        .busIn(busIn), .busOut(busOut), .dataMask(dataMask), .slaveSelected(slaveSelected));
    bgpc_arb_model bgpc_arb_model_i (.ref_clk(ref_clk), .rstn(rstn), .request(busOut.request),
        .ack(busOut.ack), .grant(mGrant), .busy(mBusy));
    task chk(input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task end_of_test;
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task t_pass(input logic [4:0] g);
        @(posedge ref_clk) tbGrant <= g;
        tick(3);
        chk(busOut.grantOut, g);
    endtask
    task t_master(input logic bm);
        @(posedge ref_clk) {byteMode, xferReady} <= {bm, 1'h1};
        tick(1);
        chk(busOut.request, 5'h10);
        for (int i = 0; i < 20 && busOut.ack !== 1'h1; i++) tick(1);
        chk({busOut.ack, busOut.request, busOut.grantOut[4]}, 7'h40);
        @(posedge ref_clk) xferReady <= 1'h0;
        for (int i = 0; i < 20 && busOut.master !== 1'h1; i++) tick(1);
        chk(busOut.master, 1'h1);
        chk(dataMask, bm ? 16'h00FF : 16'hFFFF);
        @(posedge ref_clk) {slaveAddr, addrValid, xferDone} <= {18'h3F005, 2'h3};
        @(posedge ref_clk) {addrValid, xferDone} <= 2'h0;
        #1;
        chk(busOut.master, 1'h0);
        chk(slaveSelected, 1'h0);
    endtask
    task t_slave(input logic [17:0] a, input logic exp);
        @(posedge ref_clk) {slaveAddr, addrValid} <= {a, 1'h1};
        tick(1);
        chk(slaveSelected, exp);
        @(posedge ref_clk) addrValid <= 1'h0;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'h1;
        t_pass(5'h15);
        t_pass(5'h0A);
        t_pass(5'h00);
        t_master(1'h1);
        t_master(1'h0);
        t_slave(18'h3F005, 1'h1);
        t_slave(18'h3E005, 1'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
